/* File: adc_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define OFS_FLAGS 16'ha810
`define OFS_MASK 16'ha850
`define OFS_CFG 16'hd004
`define OFS_OFFSET 16'hd008
`define OFS_GAIN 16'hd00c
`define OFS_DMACTL 16'hd010
`define OFS_DMASTAT 16'hd014
`define OFS_BEG 16'hd018
`define OFS_SIZE 16'hd01c
`define OFS_CUR 16'hd020
`define OFS_CNT 16'hd024

`define CFG_EN 0
`define CFG_SLOW_CLK 2
`define CFG_NEG_SEL 3
`define CFG_POS_SEL 7
`define CFG_NEG_RANGE 11
`define CFG_POS_RANGE 12
`define CFG_PERIOD 13
`define CFG_WMASK 16'hfffd

`define DMA_LOAD 0
`define DMA_WRAP 1
`define DMA_RST 4
`define STAT_ACT 0
`define STAT_OVF 1

`define EVT_HALF 1
`define EVT_FULL 2
`define EVT_SAT 3
`define EVT_OVF 4
`define EVT_WMASK 5'h1e

`define RST_CFG 16'h1800
`define RST_GAIN 16'h8000
`define ADDR_HI 32'h2000_0000
`define BEG_WMASK 13'h1ffe

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_MHZ 125
`define FAST_SCLK_MHZ 6
`define SLOW_SCLK_MHZ 1
`define FAST_DIV (`CLK_MHZ / `FAST_SCLK_MHZ)
`define SLOW_DIV (`CLK_MHZ / `SLOW_SCLK_MHZ)
`define STARTUP_US 21
`define STARTUP_CYC (`STARTUP_US * `CLK_MHZ)
`define BASE_SCLKS 32

`endif

/* File: adc_pkg.sv */
// Types shared by the converter control block and its result writer
package adc_pkg;

typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WARM = 2'b01,
    SEQ_SAMPLE = 2'b10
} seq_type;

typedef struct packed {
    logic en;
    logic [12:0] addr;
    logic [15:0] data;
} ram_wr_type;

typedef struct packed {
    logic enable;
    logic pos_range_sel;
    logic neg_range_sel;
    logic [3:0] pos_input_sel;
    logic [3:0] neg_input_sel;
    logic slow_sample_clk_sel;
} analog_cfg_type;

typedef struct packed {
    logic active;
    logic [11:0] cur;
    logic [11:0] cnt;
    ram_wr_type ram;
    logic full;
    logic half;
} dma_state_type;

typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [15:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] flags;
    logic [4:0] mask;
    logic [15:0] cfg;
    logic [15:0] offset;
    logic [15:0] gain;
    logic wrap;
    logic load;
    logic dma_rst;
    logic ovf_stat;
    logic [12:0] beg;
    logic [11:0] size;
    seq_type seq;
    logic [6:0] div_cnt;
    logic [11:0] warm_cnt;
    logic [13:0] samp_cnt;
    logic dbl;
    logic res_valid;
    logic [15:0] result;
    logic conv_done;
} ctrl_state_type;

endpackage : adc_pkg

/* File: adc_dma_writer.sv */
// Result writer: stores corrected results into the RAM buffer
`timescale 1ns/1ns
module adc_dma_writer
    import adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dma_rst,
    input wire logic start,
    input wire logic wrap_mode,
    input wire logic [12:0] beg,
    input wire logic [11:0] size,
    input wire logic res_valid,
    input wire logic [15:0] result,
    output logic active,
    output logic [11:0] cur_idx,
    output logic [11:0] fill_count,
    output ram_wr_type ram_wr,
    output logic full_evt,
    output logic half_evt
);

dma_state_type s_reg;
dma_state_type s_next;
logic [11:0] cnt_inc;

assign cnt_inc = s_reg.cnt + 12'h001;

always_comb begin
    s_next = s_reg;
    s_next.ram.en = 1'b0;
    s_next.full = 1'b0;
    s_next.half = 1'b0;
    if (dma_rst) begin
        s_next.active = 1'b0;
        s_next.cur = beg[12:1];
        s_next.cnt = 12'h000;
    end else if (start) begin
        s_next.active = 1'b1;
        s_next.cur = beg[12:1];
        s_next.cnt = 12'h000;
    end else if (res_valid && s_reg.active) begin
        s_next.ram.en = 1'b1;
        s_next.ram.addr = {s_reg.cur, 1'b0};
        s_next.ram.data = result;
        s_next.cur = s_reg.cur + 12'h001;
        s_next.cnt = cnt_inc;
        s_next.half = (cnt_inc == {1'b0, size[11:1]});
        if (cnt_inc >= size) begin
            s_next.full = 1'b1;
            if (wrap_mode) begin
                s_next.cur = beg[12:1];
                s_next.cnt = 12'h000;
            end else begin
                s_next.active = 1'b0;
            end
        end
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        s_reg <= '0;
    end else begin
        s_reg <= s_next;
    end
end

assign active = s_reg.active;
assign cur_idx = s_reg.cur;
assign fill_count = s_reg.cnt;
assign ram_wr = s_reg.ram;
assign full_evt = s_reg.full;
assign half_evt = s_reg.half;

endmodule : adc_dma_writer

/* File: adc_control_dma_irq.sv */
// Converter control: registers, sample sequencer, correction, event flags
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "adc_params.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module adc_control_dma_irq
    import adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [15:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [15:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output analog_cfg_type conv_cfg,
    output logic sample_clk_en,
    output logic conv_done,
    input wire logic [15:0] raw_result,
    output ram_wr_type ram_wr,
    output logic adc_irq
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_merge = (old & ~m) | (nw & m);
endfunction : lane_merge

function automatic logic [13:0] sample_len(input logic [2:0] code, input logic dbl);
    logic [13:0] base;
    base = 14'(`BASE_SCLKS) << code;
    sample_len = dbl ? {base[12:0], 1'b0} : base;
endfunction : sample_len

// Returns {saturated, corrected result}
function automatic logic [16:0] correct(input logic [15:0] raw,
                                        input logic [2:0] code,
                                        input logic [15:0] ofs,
                                        input logic [15:0] gn);
    logic [15:0] aligned;
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    logic signed [18:0] scaled;
    // Bits below the significant width carry only noise
    aligned = raw & (16'hffff << (4'd11 - {1'b0, code}));
    sum = $signed({aligned[15], aligned}) + $signed({ofs[15], ofs});
    prod = sum * $signed({1'b0, gn});
    scaled = prod[33:15];
    if (scaled > 19'sh07fff) begin
        correct = {1'b1, 16'h7fff};
    end else if (scaled < -19'sh08000) begin
        correct = {1'b1, 16'h8000};
    end else begin
        correct = {1'b0, scaled[15:0]};
    end
endfunction : correct

////////////////////////////////////////////////////////////////////////////////
// State

ctrl_state_type s_reg;
ctrl_state_type s_next;
logic dma_active;
logic [11:0] dma_cur;
logic [11:0] dma_cnt;
logic full_evt;
logic half_evt;
logic dma_start;
logic wr_commit;
logic cfg_wr;
logic tick;
logic [6:0] div_reload;
logic [16:0] corr;
logic [31:0] mg;
logic [31:0] rd_val;
logic [1:0] rd_resp;

assign dma_start = s_reg.load && !dma_active && !s_reg.dma_rst;
assign wr_commit = s_reg.aw_got && s_reg.w_got;
assign tick = (s_reg.div_cnt == 7'h00);
assign div_reload = s_reg.cfg[`CFG_SLOW_CLK] ? 7'(`SLOW_DIV - 1) : 7'(`FAST_DIV - 1);
assign corr = correct(raw_result, s_reg.cfg[15:13], s_reg.offset, s_reg.gain);

adc_dma_writer u_writer (
    .aclk(aclk),
    .aresetn(aresetn),
    .dma_rst(s_reg.dma_rst),
    .start(dma_start),
    .wrap_mode(s_reg.wrap),
    .beg(s_reg.beg),
    .size(s_reg.size),
    .res_valid(s_reg.res_valid),
    .result(s_reg.result),
    .active(dma_active),
    .cur_idx(dma_cur),
    .fill_count(dma_cnt),
    .ram_wr(ram_wr),
    .full_evt(full_evt),
    .half_evt(half_evt)
);

////////////////////////////////////////////////////////////////////////////////
// Read mux

always_comb begin
    rd_val = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (araddr)
        `OFS_FLAGS: rd_val = {27'h0, s_reg.flags};
        `OFS_MASK: rd_val = {27'h0, s_reg.mask};
        `OFS_CFG: rd_val = {16'h0, s_reg.cfg};
        `OFS_OFFSET: rd_val = {16'h0, s_reg.offset};
        `OFS_GAIN: rd_val = {16'h0, s_reg.gain};
        `OFS_DMACTL: rd_val = {30'h0, s_reg.wrap, s_reg.load};
        `OFS_DMASTAT: rd_val = {30'h0, s_reg.ovf_stat, dma_active};
        `OFS_BEG: rd_val = `ADDR_HI | {19'h0, s_reg.beg};
        `OFS_SIZE: rd_val = {20'h0, s_reg.size};
        `OFS_CUR: rd_val = `ADDR_HI | {19'h0, dma_cur, 1'b0};
        `OFS_CNT: rd_val = {20'h0, dma_cnt};
        default: rd_resp = `RESP_SLVERR;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Next state

always_comb begin
    s_next = s_reg;
    s_next.dma_rst = 1'b0;
    s_next.res_valid = 1'b0;
    s_next.conv_done = 1'b0;
    cfg_wr = 1'b0;
    mg = lane_merge(32'h0, s_reg.wdata, s_reg.wstrb);

    // Read channel
    if (s_reg.rvalid && rready) begin
        s_next.rvalid = 1'b0;
    end
    if (arvalid && !s_reg.rvalid) begin
        s_next.rvalid = 1'b1;
        s_next.rdata = rd_val;
        s_next.rresp = rd_resp;
    end

    // Write channels, taken in either order
    if (s_reg.bvalid && bready) begin
        s_next.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
        s_next.aw_got = 1'b1;
        s_next.waddr = awaddr;
    end
    if (wvalid && wready) begin
        s_next.w_got = 1'b1;
        s_next.wdata = wdata;
        s_next.wstrb = wstrb;
    end

    if (dma_start) begin
        s_next.load = 1'b0;
    end

    if (wr_commit) begin
        s_next.aw_got = 1'b0;
        s_next.w_got = 1'b0;
        s_next.bvalid = 1'b1;
        s_next.bresp = `RESP_OKAY;
        case (s_reg.waddr)
            `OFS_FLAGS: begin
                s_next.flags = s_reg.flags & ~(mg[4:0] & `EVT_WMASK);
            end
            `OFS_MASK: begin
                mg = lane_merge({27'h0, s_reg.mask}, s_reg.wdata, s_reg.wstrb);
                s_next.mask = mg[4:0] & `EVT_WMASK;
            end
            `OFS_CFG: begin
                mg = lane_merge({16'h0, s_reg.cfg}, s_reg.wdata, s_reg.wstrb);
                s_next.cfg = mg[15:0] & `CFG_WMASK;
                cfg_wr = 1'b1;
            end
            `OFS_OFFSET: begin
                mg = lane_merge({16'h0, s_reg.offset}, s_reg.wdata, s_reg.wstrb);
                s_next.offset = mg[15:0];
            end
            `OFS_GAIN: begin
                mg = lane_merge({16'h0, s_reg.gain}, s_reg.wdata, s_reg.wstrb);
                s_next.gain = mg[15:0];
            end
            `OFS_DMACTL: begin
                mg = lane_merge({30'h0, s_reg.wrap, 1'b0}, s_reg.wdata, s_reg.wstrb);
                s_next.wrap = mg[`DMA_WRAP];
                if (mg[`DMA_RST]) begin
                    // Reset beats a load written in the same word
                    s_next.dma_rst = 1'b1;
                    s_next.load = 1'b0;
                    s_next.ovf_stat = 1'b0;
                end else if (mg[`DMA_LOAD]) begin
                    s_next.load = 1'b1;
                end
            end
            `OFS_BEG: begin
                mg = lane_merge({19'h0, s_reg.beg}, s_reg.wdata, s_reg.wstrb);
                s_next.beg = mg[12:0] & `BEG_WMASK;
            end
            `OFS_SIZE: begin
                mg = lane_merge({20'h0, s_reg.size}, s_reg.wdata, s_reg.wstrb);
                s_next.size = mg[11:0];
            end
            `OFS_DMASTAT, `OFS_CUR, `OFS_CNT: begin
                s_next.bresp = `RESP_OKAY;
            end
            default: s_next.bresp = `RESP_SLVERR;
        endcase
    end

    // Sample clock divider
    s_next.div_cnt = tick ? div_reload : s_reg.div_cnt - 7'h01;

    // Conversion sequencer
    case (s_reg.seq)
        SEQ_IDLE: begin
            if (s_reg.cfg[`CFG_EN]) begin
                s_next.seq = SEQ_WARM;
                s_next.warm_cnt = 12'(`STARTUP_CYC - 1);
                s_next.samp_cnt = 14'h0000;
                s_next.dbl = 1'b1;
            end
        end
        SEQ_WARM: begin
            if (s_reg.warm_cnt == 12'h000) begin
                s_next.seq = SEQ_SAMPLE;
            end else begin
                s_next.warm_cnt = s_reg.warm_cnt - 12'h001;
            end
        end
        SEQ_SAMPLE: begin
            if (tick) begin
                if (s_reg.samp_cnt == sample_len(s_reg.cfg[15:13], s_reg.dbl) - 14'h0001) begin
                    s_next.samp_cnt = 14'h0000;
                    s_next.dbl = 1'b0;
                    s_next.conv_done = 1'b1;
                    s_next.res_valid = 1'b1;
                    s_next.result = corr[15:0];
                end else begin
                    s_next.samp_cnt = s_reg.samp_cnt + 14'h0001;
                end
            end
        end
        default: s_next.seq = SEQ_IDLE;
    endcase

    // A config write restarts the sample, the DMA keeps running
    if (!s_next.cfg[`CFG_EN]) begin
        s_next.seq = SEQ_IDLE;
        s_next.res_valid = 1'b0;
        s_next.conv_done = 1'b0;
    end else if (cfg_wr && s_reg.seq != SEQ_IDLE) begin
        s_next.samp_cnt = 14'h0000;
        s_next.dbl = 1'b1;
        s_next.res_valid = 1'b0;
        s_next.conv_done = 1'b0;
    end

    // Event sets come last so a set wins over a clear in the same cycle
    if (s_reg.res_valid && !dma_active) begin
        s_next.flags[`EVT_OVF] = 1'b1;
        s_next.ovf_stat = 1'b1;
    end
    if (s_next.res_valid && corr[16]) begin
        s_next.flags[`EVT_SAT] = 1'b1;
    end
    if (full_evt) begin
        s_next.flags[`EVT_FULL] = 1'b1;
    end
    if (half_evt) begin
        s_next.flags[`EVT_HALF] = 1'b1;
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        s_reg <= '0;
        s_reg.cfg <= `RST_CFG;
        s_reg.gain <= `RST_GAIN;
        s_reg.seq <= SEQ_IDLE;
    end else begin
        s_reg <= s_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

assign awready = !s_reg.aw_got && !s_reg.bvalid;
assign wready = !s_reg.w_got && !s_reg.bvalid;
assign bvalid = s_reg.bvalid;
assign bresp = s_reg.bresp;
assign arready = !s_reg.rvalid;
assign rvalid = s_reg.rvalid;
assign rdata = s_reg.rdata;
assign rresp = s_reg.rresp;

assign conv_cfg.enable = s_reg.cfg[`CFG_EN];
assign conv_cfg.pos_range_sel = s_reg.cfg[`CFG_POS_RANGE];
assign conv_cfg.neg_range_sel = s_reg.cfg[`CFG_NEG_RANGE];
assign conv_cfg.pos_input_sel = s_reg.cfg[`CFG_POS_SEL +: 4];
assign conv_cfg.neg_input_sel = s_reg.cfg[`CFG_NEG_SEL +: 4];
assign conv_cfg.slow_sample_clk_sel = s_reg.cfg[`CFG_SLOW_CLK];
assign sample_clk_en = tick && (s_reg.seq == SEQ_SAMPLE);
assign conv_done = s_reg.conv_done;

// Only pending flags whose mask bit is set reach the request line
assign adc_irq = |(s_reg.flags & s_reg.mask);

endmodule : adc_control_dma_irq

/* File: adc_monitor.sv */
// Port-level checker for the converter control block
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_monitor
    import adc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [15:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire analog_cfg_type conv_cfg,
    input wire logic sample_clk_en,
    input wire logic conv_done,
    input wire ram_wr_type ram_wr
);
localparam int FAST_GAP = `FAST_DIV - 1;
localparam int SLOW_GAP = `SLOW_DIV - 1;
logic [7:0] gap_reg;
logic seen_reg;
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
// A config write may change the divider reload, so spacing is only judged between writes
always_ff @(posedge aclk) begin
    if (!aresetn || !conv_cfg.enable || awvalid || bvalid || $changed(conv_cfg)) begin
        seen_reg <= 1'b0;
    end else if (sample_clk_en) begin
        seen_reg <= 1'b1;
    end
    gap_reg <= sample_clk_en ? 8'h00 : gap_reg + 8'h01;
end
////////////////////////////////////////////////////////////////////////////////
property p_sclk_gap;
    sample_clk_en && seen_reg |->
        gap_reg == (conv_cfg.slow_sample_clk_sel ? SLOW_GAP : FAST_GAP);
endproperty
a_sclk_gap: assert property (p_sclk_gap) else $error("sample clock spacing");
property p_wr_answer;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
endproperty
a_wr_answer: assert property (p_wr_answer) else $error("write answer timing");
property p_rd_answer;
    arvalid && arready |=> rvalid;
endproperty
a_rd_answer: assert property (p_rd_answer) else $error("read answer timing");
property p_arready;
    arready == !rvalid;
endproperty
a_arready: assert property (p_arready) else $error("read address ready");
property p_done_gap;
    conv_done |=> !conv_done [*8];
endproperty
a_done_gap: assert property (p_done_gap) else $error("conversions too close");
property p_done_en;
    conv_done |-> $past(conv_cfg.enable);
endproperty
a_done_en: assert property (p_done_en) else $error("conversion while off");
property p_wr_src;
    ram_wr.en |-> $past(conv_done);
endproperty
a_wr_src: assert property (p_wr_src) else $error("store without result");
property p_wr_align;
    ram_wr.en |-> !ram_wr.addr[0];
endproperty
a_wr_align: assert property (p_wr_align) else $error("odd store address");
property p_wr_pulse;
    ram_wr.en |=> !ram_wr.en;
endproperty
a_wr_pulse: assert property (p_wr_pulse) else $error("store held");
c_done: cover property (conv_done);
c_store: cover property (ram_wr.en);
c_slverr: cover property (bvalid && bresp == `RESP_SLVERR);
c_slow: cover property (sample_clk_en && conv_cfg.slow_sample_clk_sel);
endmodule : adc_monitor

/* File: adc_core_model.sv */
// Behavioural converter core and result RAM on the far side of the block
`timescale 1ns/1ns
module adc_core_model
    import adc_pkg::*;
(
    input wire logic aclk,
    input wire analog_cfg_type conv_cfg,
    input wire logic [15:0] level,
    input wire ram_wr_type ram_wr,
    output logic [15:0] raw_result
);
logic [15:0] mem [0:4095];
logic flip_reg = 1'b0;
always_ff @(posedge aclk) begin
    flip_reg <= !flip_reg;
    if (ram_wr.en) begin
        mem[ram_wr.addr[12:1]] <= ram_wr.data;
    end
end
// An idle core shows a moving pattern so no stale sample passes for a fresh one
assign raw_result = (conv_cfg.enable || flip_reg) ? level : ~level;
endmodule : adc_core_model

/* File: tb.sv */
// Register-level testbench for the converter control block
`timescale 1ns/1ns
`include "adc_params.svh"
module tb
    import adc_pkg::*;
();
logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
logic [15:0] awaddr = 16'h0, araddr = 16'h0, level = 16'h4000, raw_result;
logic [31:0] wdata = 32'h0, rdata, rdv;
logic [3:0] wstrb = 4'h0;
logic [1:0] bresp, rresp, wres, rrs;
logic sample_clk_en, conv_done, adc_irq;
analog_cfg_type conv_cfg;
ram_wr_type ram_wr;
int error_cnt = 0, samples_checked = 0, cyc = 0, t, i;
logic [15:0] ra [11] = '{`OFS_FLAGS, `OFS_MASK, `OFS_CFG, `OFS_OFFSET, `OFS_GAIN,
    `OFS_DMACTL, `OFS_DMASTAT, `OFS_BEG, `OFS_SIZE, `OFS_CUR, `OFS_CNT};
logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h1800, 32'h0, 32'h8000, 32'h0, 32'h0,
    32'h20000000, 32'h0, 32'h20000000, 32'h0};
logic [15:0] cl [4] = '{16'h4321, 16'h4000, 16'h7800, 16'h8000};
logic [15:0] co [4] = '{16'h0123, 16'h0000, 16'h0000, 16'h0000};
logic [15:0] cg [4] = '{16'h8000, 16'h4000, 16'hffff, 16'hffff};
adc_control_dma_irq dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .conv_cfg, .sample_clk_en, .conv_done, .raw_result, .ram_wr, .adc_irq);
adc_core_model model_u (.aclk, .conv_cfg, .level, .ram_wr, .raw_result);
initial begin
    forever #4 aclk = ~aclk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        error_cnt++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask : check
task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask : test_done
task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
        @(negedge aclk);
        ta = awready && !da;
        tw = wready && !dw;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        da = da || ta;
        dw = dw || tw;
    end
    do @(negedge aclk); while (!bvalid);
    wres = bresp;
    @(posedge aclk);
    bready <= 1'b0;
endtask : wr
task automatic rd(input logic [15:0] a);
    logic ta;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    ta = 1'b0;
    while (!ta) begin
        @(negedge aclk);
        ta = arready;
        @(posedge aclk);
    end
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rdv = rdata;
    rrs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
endtask : rd
task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    rd(a);
    check(rdv, e);
endtask : rchk
task automatic wait_done();
    t = 0;
    do begin
        @(negedge aclk);
        t++;
    end while (!conv_done);
endtask : wait_done
task automatic wait_wr();
    do @(negedge aclk); while (!ram_wr.en);
endtask : wait_wr
function automatic logic [15:0] corr(input logic [15:0] r, input logic [15:0] o,
    input logic [15:0] g);
    longint s;
    s = (longint'($signed(r & 16'hf800)) + longint'($signed(o))) * longint'(g);
    s = s >>> 15;
    if (s > 32767) return 16'h7fff;
    if (s < -32768) return 16'h8000;
    return s[15:0];
endfunction : corr
////////////////////////////////////////////////////////////////////////////////
// The run needs under 20000 cycles, so this ceiling only trips on a hang
always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
        error_cnt++;
        test_done();
    end
end
initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 11; i++) rchk(ra[i], rv[i]);
    rd(16'hd000);
    check(32'(rrs), 32'(`RESP_SLVERR));
    check(rdv, 32'h0);
    wr(16'hd000, 32'h1);
    check(32'(wres), 32'(`RESP_SLVERR));
    wr(`OFS_CNT, 32'h5);
    rchk(`OFS_CNT, 32'h0);
    $display("test registers done");
    wr(`OFS_CFG, 32'h1801);
    wait_done();
    // Startup plus 64 sample clocks, give or take one sample clock of divider phase
    check(32'(t >= 3885 && t <= 3925), 32'h1);
    wait_done();
    check(32'(t), 32'd640);
    rchk(`OFS_FLAGS, 32'h10);
    rchk(`OFS_DMASTAT, 32'h2);
    @(negedge aclk);
    check(32'(adc_irq), 32'h0);
    wr(`OFS_MASK, 32'h10);
    @(negedge aclk);
    check(32'(adc_irq), 32'h1);
    wr(`OFS_FLAGS, 32'h0);
    rchk(`OFS_FLAGS, 32'h10);
    wr(`OFS_FLAGS, 32'h10);
    rchk(`OFS_FLAGS, 32'h0);
    @(negedge aclk);
    check(32'(adc_irq), 32'h0);
    wr(`OFS_MASK, 32'h0);
    wr(`OFS_CFG, 32'h154b);
    wait_done();
    check(32'(t > 1200 && t < 1330), 32'h1);
    rchk(`OFS_CFG, 32'h1549);
    check(32'(conv_cfg), 32'h00000d52);
    $display("test conversion done");
    wr(`OFS_DMACTL, 32'h10);
    rchk(`OFS_DMASTAT, 32'h0);
    rchk(`OFS_DMACTL, 32'h0);
    wr(`OFS_BEG, 32'h0101);
    rchk(`OFS_BEG, 32'h20000100);
    wr(`OFS_SIZE, 32'h4);
    wr(`OFS_DMACTL, 32'h1);
    wr(`OFS_FLAGS, 32'h1e);
    rchk(`OFS_DMASTAT, 32'h1);
    rchk(`OFS_DMACTL, 32'h0);
    for (i = 0; i < 4; i++) begin
        wait_wr();
        check(32'(ram_wr.addr), 32'h100 + 32'(2 * i));
        repeat (3) @(negedge aclk);
        if (i == 1) rchk(`OFS_FLAGS, 32'h2);
    end
    rchk(`OFS_FLAGS, 32'h6);
    rchk(`OFS_DMASTAT, 32'h0);
    rchk(`OFS_CNT, 32'h4);
    rchk(`OFS_CUR, 32'h20000108);
    check(32'(model_u.mem[131]), 32'h4000);
    wait_done();
    repeat (3) @(negedge aclk);
    rchk(`OFS_FLAGS, 32'h16);
    wr(`OFS_DMACTL, 32'h10);
    wr(`OFS_SIZE, 32'h2);
    wr(`OFS_DMACTL, 32'h3);
    for (i = 0; i < 2; i++) wait_wr();
    repeat (3) @(negedge aclk);
    rchk(`OFS_CUR, 32'h20000100);
    rchk(`OFS_CNT, 32'h0);
    rchk(`OFS_DMASTAT, 32'h1);
    $display("test dma done");
    for (i = 0; i < 4; i++) begin
        wait_done();
        @(posedge aclk);
        level <= cl[i];
        wr(`OFS_OFFSET, 32'(co[i]));
        wr(`OFS_GAIN, 32'(cg[i]));
        wr(`OFS_FLAGS, 32'h1e);
        wait_wr();
        check(32'(ram_wr.data), 32'(corr(cl[i], co[i], cg[i])));
        repeat (3) @(negedge aclk);
        rd(`OFS_FLAGS);
        check(32'(rdv[3]), 32'(i > 1));
    end
    $display("test correction done");
    wr(`OFS_CFG, 32'h1505);
    rchk(`OFS_DMASTAT, 32'h1);
    repeat (400) @(negedge aclk);
    check(32'(conv_cfg.slow_sample_clk_sel), 32'h1);
    wr(`OFS_CFG, 32'h1504);
    t = 0;
    for (i = 0; i < 700; i++) begin
        @(negedge aclk);
        t += 32'(conv_done);
    end
    check(32'(t), 32'h0);
    $display("test modes done");
    test_done();
end
endmodule : tb
bind adc_control_dma_irq adc_monitor mon_u (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .bvalid, .bresp, .arvalid, .arready, .rvalid, .conv_cfg,
    .sample_clk_en, .conv_done, .ram_wr);
